// file: fetp_mac_model.sv
// Behavioural MAC driving the MII transmit side
`timescale 1ns/1ps
module fetp_mac_model
  import fetp_pkg::*;
(
  input wire logic run,
  output logic txClk,
  output fetp_pkg::fetp_mii_tx_t txIn
);
  fetp_mii_tx_t frm[$];
  // Clock stops low between bursts so symbol slots can be counted
  initial
  begin
    txClk = 1'b0;
    txIn = '0;
    #137;
    forever
    begin
      #400;
      if (run || txClk) txClk = ~txClk;
    end
  end
  // Data moves on the falling edge, away from the sampled rising edge
  always @(negedge txClk)
    if (frm.size() > 0) txIn <= frm.pop_front();
    else txIn <= '{en: 1'b0, er: 1'b0, d: ~txIn.d};
endmodule : fetp_mac_model

// file: fetp_pkg.sv
// Constants, types and coding functions of the 100 Mbit/s transmit coding block
// Summary of operation
// - Map each data nibble to its 5-bit code-group
// - Frame start: J then K replace preamble
// - Frame end: T then R replace first idles
// - Idle code-groups fill time between frames
// - Transmit error inside frame sends HALT
// - Delimiters are never replaced by HALT
// - Decoder gives 0Eh for invalid code-groups
// - Halt-accept bit decodes HALT as 05h
// - Scrambler LFSR: new bit = x[n-11]^x[n-9]
// - Code-group XORed with scrambler output
// - Seed-load bit loads seed into LFSR
// - Seed is PHY address plus user seed
// - Scrambled code-group shifted out serially
// - NRZI: toggle on one, hold on zero
// - Half duplex: collision on simultaneous activity
// - Full duplex: collision output stays low unless the collision-test bit is set
// - Collision-test bit in control register
// - Separate bypass for each coding function
// - Loopback returns transmit path to receive
// - Bypass: fifth bit on error lines
// - One nibble per transmit clock cycle
package fetp_pkg;

  // ----------------------------------------------------------------
  // Register map (index, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_IDX = 8'h00;
  localparam logic [7:0] REG_STAT_IDX = 8'h10;
  localparam logic [7:0] REG_DEC_IDX = 8'h11;
  localparam logic [7:0] REG_PCS_IDX = 8'h18;
  localparam logic [7:0] REG_SEED_IDX = 8'h19;

  localparam int CTRL_COLTEST_BIT = 7;
  localparam int CTRL_FDX_BIT = 8;
  localparam int CTRL_LOOP_BIT = 14;
  localparam int PCS_SYMBYP_BIT = 0;
  localparam int PCS_SCRBYP_BIT = 1;
  localparam int PCS_NRZIBYP_BIT = 2;
  localparam int PCS_SEEDLD_BIT = 4;
  localparam int PCS_ACCHALT_BIT = 5;
  localparam int PCS_ALIGNBYP_BIT = 6;
  localparam int SEED_PHYAD_LSB = 11;
  localparam int SEED_COPY_LSB = 6;

  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] PCS_RST = 16'h0000;
  localparam logic [4:0] PHYAD_RST = 5'h00;
  localparam logic [5:0] USEED_RST = 6'h00;

  // ----------------------------------------------------------------
  // Code-groups and scrambler
  // ----------------------------------------------------------------
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_HALT = 5'h04;
  localparam logic [3:0] DEC_INVALID = 4'hE;
  localparam logic [3:0] DEC_HALT = 4'h5;
  localparam logic [10:0] LFSR_RST = 11'h7FF;
  localparam logic [10:0] SEED_NONZERO = 11'h7FF;
  localparam logic [2:0] SYM_BITS = 3'h5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_J = 2'b01,
    TX_DATA = 2'b11,
    TX_T = 2'b10
  } fetp_txst_t;

  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } fetp_mii_tx_t;

  typedef struct packed {
    logic [3:0] d;
    logic dv;
    logic er;
  } fetp_mii_rx_t;

  // ----------------------------------------------------------------
  // Coding functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] fetp_encode(input logic [3:0] nib);
    logic [4:0] c;
    c = CG_IDLE;
    unique case (nib)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      4'hF: c = 5'h1D;
    endcase
    return c;
  endfunction : fetp_encode

  // Returns {invalid flag, nibble}
  function automatic logic [4:0] fetp_decode(input logic [4:0] cg, input logic acceptHalt);
    logic [4:0] r;
    r = {1'b1, DEC_INVALID};
    for (int i = 0; i < 16; i++)
    begin
      if (fetp_encode(4'(i)) == cg)
        r = {1'b0, 4'(i)};
    end
    if (cg == CG_J || cg == CG_K)
      r = {1'b0, DEC_HALT};
    if (cg == CG_IDLE || cg == CG_T || cg == CG_R)
      r = {1'b0, DEC_INVALID};
    if (cg == CG_HALT)
      r = acceptHalt ? {1'b0, DEC_HALT} : {1'b1, DEC_INVALID};
    return r;
  endfunction : fetp_decode

  // Steps the LFSR five times; returns {new state, 5-bit mask, first bit in [4]}
  function automatic logic [15:0] fetp_lfsr5(input logic [10:0] s);
    logic [10:0] st;
    logic [4:0] m;
    logic b;
    st = s;
    m = 5'h00;
    for (int i = 4; i >= 0; i--)
    begin
      b = st[10] ^ st[8];
      m[i] = b;
      st = {st[9:0], b};
    end
    return {st, m};
  endfunction : fetp_lfsr5

  typedef struct packed {
    logic clkS1;
    logic clkS2;
    logic clkS3;
    fetp_mii_tx_t txS1;
    fetp_mii_tx_t txS2;
    logic rxActS1;
    logic rxActS2;
    fetp_txst_t txSt;
    logic [10:0] lfsr;
    logic [4:0] shReg;
    logic [2:0] bitCnt;
    logic line;
    logic col;
    fetp_mii_rx_t rx;
    logic [15:0] ctrl;
    logic [15:0] pcs;
    logic [4:0] phyAd;
    logic [5:0] userSeed;
    logic [4:0] decCode;
    logic apValid;
    logic apWrite;
    logic [7:0] apIdx;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } fetp_state_t;

endpackage : fetp_pkg

// file: fetp_tx_pcs.sv
// Transmit coding sublayer: encoder, scrambler, serializer, collision and AHB-Lite registers
`timescale 1ns/1ps
module fetp_tx_pcs (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic txClk,
  input wire fetp_pkg::fetp_mii_tx_t txIn,
  input wire logic rxActive,
  output fetp_pkg::fetp_mii_rx_t rxOut,
  output logic col,
  output logic txLine,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  import fetp_pkg::*;

  fetp_state_t q;
  fetp_state_t d;

  logic linkEdge;
  logic codeBypass;
  logic [4:0] code;
  logic [4:0] scr;
  logic [15:0] step;
  logic [10:0] seed;
  logic [4:0] dec;
  logic txBusy;
  logic [31:0] rdMux;
  logic bitNow;

  assign rxOut = q.rx;
  assign col = q.col;
  assign txLine = q.line;
  assign hreadyout = q.hreadyout;
  assign hresp = q.hresp;
  assign hrdata = q.hrdata;

  always_comb
  begin
    d = q;
    linkEdge = 1'b0;
    code = CG_IDLE;
    scr = CG_IDLE;
    step = 16'h0000;
    seed = 11'h000;
    dec = 5'h00;
    txBusy = 1'b0;
    rdMux = 32'h0000_0000;
    bitNow = 1'b0;

    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    // The transmit clock and its signals come from the MAC side, so each passes two flops
    d.clkS1 = txClk;
    d.clkS2 = q.clkS1;
    d.clkS3 = q.clkS2;
    d.txS1 = txIn;
    d.txS2 = q.txS1;
    d.rxActS1 = rxActive;
    d.rxActS2 = q.rxActS1;
    linkEdge = q.clkS2 & ~q.clkS3;

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    d.hreadyout = 1'b1;
    d.hresp = 1'b0;
    if (q.apValid && q.apWrite)
    begin
      unique case (q.apIdx)
        REG_CTRL_IDX: d.ctrl = hwdata[15:0];
        REG_PCS_IDX: d.pcs = hwdata[15:0];
        REG_SEED_IDX:
        begin
          d.phyAd = hwdata[SEED_PHYAD_LSB +: 5];
          d.userSeed = hwdata[5:0];
        end
        REG_DEC_IDX: d.decCode = hwdata[4:0];
        default: d.decCode = q.decCode;
      endcase
    end
    // Seed load is a command: the bit never stays set
    d.pcs[PCS_SEEDLD_BIT] = 1'b0;

    txBusy = (q.txSt != TX_IDLE) || q.txS2.en;
    dec = fetp_decode(d.decCode, d.pcs[PCS_ACCHALT_BIT]);
    unique case (haddr[9:2])
      REG_CTRL_IDX: rdMux = {16'h0000, d.ctrl};
      REG_PCS_IDX: rdMux = {16'h0000, d.pcs};
      REG_SEED_IDX: rdMux = {16'h0000, d.phyAd, d.phyAd, d.userSeed};
      REG_STAT_IDX: rdMux = {19'h0_0000, q.lfsr, q.col, txBusy};
      REG_DEC_IDX: rdMux = {19'h0_0000, d.decCode, 3'h0, dec};
      default: rdMux = 32'h0000_0000;
    endcase
    if (|haddr[31:10])
      rdMux = 32'h0000_0000;
    d.apValid = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      // Reads see a write made in the cycle just before
      d.apValid = ~|haddr[31:10];
      d.apWrite = hwrite;
      d.apIdx = haddr[9:2];
      if (!hwrite)
        d.hrdata = rdMux;
    end

    // ----------------------------------------------------------------
    // Symbol encoder and scrambler, one code-group per link clock
    // ----------------------------------------------------------------
    codeBypass = q.pcs[PCS_SYMBYP_BIT] | q.pcs[PCS_ALIGNBYP_BIT];
    seed = {q.phyAd, q.userSeed};
    if (seed == 11'h000)
      seed = SEED_NONZERO;
    step = fetp_lfsr5(q.lfsr);
    if (linkEdge)
    begin
      if (codeBypass)
      begin
        code = {q.txS2.er, q.txS2.d};
        d.txSt = TX_IDLE;
      end
      else
      begin
        unique case (q.txSt)
          TX_IDLE:
          begin
            if (q.txS2.en)
            begin
              code = CG_J;
              d.txSt = TX_J;
            end
            else
            begin
              code = CG_IDLE;
            end
          end
          TX_J:
          begin
            code = CG_K;
            d.txSt = TX_DATA;
          end
          TX_DATA:
          begin
            if (!q.txS2.en)
            begin
              code = CG_T;
              d.txSt = TX_T;
            end
            else if (q.txS2.er)
              code = CG_HALT;
            else
              code = fetp_encode(q.txS2.d);
          end
          TX_T:
          begin
            code = CG_R;
            d.txSt = TX_IDLE;
          end
        endcase
      end
      scr = q.pcs[PCS_SCRBYP_BIT] ? code : code ^ step[4:0];
      d.lfsr = step[15:5];
      d.shReg = scr;
      d.bitCnt = SYM_BITS;

      // Loopback hands the unscrambled stream to the receive outputs
      if (q.ctrl[CTRL_LOOP_BIT])
      begin
        dec = fetp_decode(code, q.pcs[PCS_ACCHALT_BIT]);
        if (codeBypass)
          d.rx = '{d: code[3:0], dv: q.txS2.en, er: code[4]};
        else
        begin
          // J opens the preamble, so it is handed over as valid like K
          d.rx.dv = (code != CG_IDLE) && (code != CG_T) && (code != CG_R);
          d.rx.d = d.rx.dv ? dec[3:0] : 4'h0;
          d.rx.er = d.rx.dv & dec[4];
        end
      end
      else
        d.rx = '0;
    end
    else if (q.bitCnt != 3'h0)
    begin
      // Serializer: bit 4 goes first, one bit per core cycle
      bitNow = q.shReg[4];
      d.shReg = {q.shReg[3:0], 1'b0};
      d.bitCnt = q.bitCnt - 3'h1;
      if (q.pcs[PCS_NRZIBYP_BIT])
        d.line = bitNow;
      else
        d.line = q.line ^ bitNow;
    end

    // A seed load takes priority over the scrambler's own step
    if (q.apValid && q.apWrite && q.apIdx == REG_PCS_IDX && hwdata[PCS_SEEDLD_BIT])
      d.lfsr = seed;

    // ----------------------------------------------------------------
    // Collision indication
    // ----------------------------------------------------------------
    if (q.ctrl[CTRL_COLTEST_BIT])
      d.col = q.txS2.en;
    else if (q.ctrl[CTRL_FDX_BIT])
      d.col = 1'b0;
    else
      d.col = txBusy & q.rxActS2;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.hreadyout <= 1'b1;
      q.lfsr <= LFSR_RST;
      q.ctrl <= CTRL_RST;
      q.pcs <= PCS_RST;
      q.phyAd <= PHYAD_RST;
      q.userSeed <= USEED_RST;
    end
    else
      q <= d;
  end

endmodule : fetp_tx_pcs

// file: fetp_tx_pcs_checker.sv
// Assertion checker for the transmit coding block
`timescale 1ns/1ps
module fetp_tx_pcs_checker
  import fetp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire fetp_pkg::fetp_mii_tx_t txIn,
  input wire logic rxActive,
  input wire logic col,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic rdPh_r;
  logic wrPh_r;
  logic [11:0] adr_r;
  logic [15:0] ctrl_r;
  logic [2:0] quiet_r;
  wire take = hsel && hready && htrans[1];
  // Shadow of control, so read data is tied to the last write
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdPh_r <= 1'b0;
      wrPh_r <= 1'b0;
      adr_r <= 12'h000;
      ctrl_r <= CTRL_RST;
      quiet_r <= 3'h0;
    end
    else
    begin
      rdPh_r <= take && !hwrite;
      wrPh_r <= take && hwrite;
      if (take) adr_r <= haddr[11:0];
      if (wrPh_r && adr_r == 12'h000) ctrl_r <= hwdata[15:0];
      quiet_r <= (txIn.en || rxActive) ? 3'h0 : quiet_r + 3'(quiet_r != 3'h7);
    end
  end
  property p_resp; hresp == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("bad response");
  property p_ready; hreadyout == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_upper; rdPh_r |-> hrdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_hold; !(take && !hwrite) |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; take && !hwrite && haddr[31:10] != 22'h0 |=> hrdata == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ctrl; rdPh_r && adr_r == 12'h000 |-> hrdata[8:7] == ctrl_r[8:7]; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback");
  property p_seedld; rdPh_r && adr_r == 12'h060 |-> !hrdata[4]; endproperty
  a_seedld: assert property (p_seedld) else $error("seed load stuck");
  property p_col; col |-> quiet_r < 3'h6; endproperty
  a_col: assert property (p_col) else $error("collision without activity");
  property p_fdx; (ctrl_r[8] && !ctrl_r[7]) [*2] |-> !col; endproperty
  a_fdx: assert property (p_fdx) else $error("collision in full duplex");
endmodule : fetp_tx_pcs_checker
bind fetp_tx_pcs fetp_tx_pcs_checker u_fetp_tx_pcs_checker (.*);

// file: fetp_tx_pcs_tb.sv
// Self-checking testbench for the transmit coding block
`timescale 1ns/1ps
module fetp_tx_pcs_tb;
  import fetp_pkg::*;
  localparam logic [4:0] CG_TAB [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic run = 1'b0;
  logic txClk;
  fetp_mii_tx_t txIn;
  logic rxActive = 1'b0;
  fetp_mii_rx_t rxOut;
  logic col;
  logic txLine;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic rec = 1'b0;
  logic colSeen = 1'b0;
  logic [4:0] rxq[$];
  logic [31:0] rd;
  int mismatches = 0;
  int testsRun = 0;
  int togCnt = 0;
  assign hready = hreadyout;
  always #50 core_clk = ~core_clk;
  always @(txLine) togCnt++;
  always @(posedge txClk) if (rec) rxq.push_back({rxOut.d, rxOut.er});
  always @(posedge core_clk) if (col === 1'b1) colSeen <= 1'b1;
  fetp_mac_model u_fetp_mac_model (.run(run), .txClk(txClk), .txIn(txIn));
  fetp_tx_pcs u_fetp_tx_pcs (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    if (mismatches == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  function automatic logic [4:0] dec_exp(input logic [4:0] c, input logic acc);
    logic [4:0] r;
    r = {1'b1, DEC_INVALID};
    for (int i = 0; i < 16; i++)
      if (CG_TAB[i] == c) r = {1'b0, 4'(i)};
    if (c == CG_J || c == CG_K) r = {1'b0, DEC_HALT};
    if (c == CG_IDLE || c == CG_T || c == CG_R) r = {1'b0, DEC_INVALID};
    if (c == CG_HALT) r = acc ? {1'b0, DEC_HALT} : {1'b1, DEC_INVALID};
    return r;
  endfunction : dec_exp
  // Idle is all ones, so line toggles equal the zero bits of the mask
  function automatic logic [18:0] scr_run(input logic [10:0] s, input int n);
    logic b;
    logic [7:0] k;
    k = 8'h00;
    repeat (5 * n)
    begin
      b = s[10] ^ s[8];
      s = {s[9:0], b};
      k = k + 8'(!b);
    end
    return {s, k};
  endfunction : scr_run
  task automatic frame(input logic [15:0] ctrl, input logic rx, input logic expCol);
    int n;
    int k;
    logic [4:0] e[$];
    fetp_mii_tx_t t;
    bus(1, 12'h000, 32'(ctrl));
    rxActive <= rx;
    // Let the previous mode's collision output settle, away from the sampling edge
    repeat (4) @(negedge core_clk);
    colSeen = 1'b0;
    n = 6 + $urandom_range(6);
    for (int i = 0; i < n; i++)
    begin
      t = '{en: 1'b1, er: ($urandom_range(3) == 0) || (i == n - 1), d: 4'($urandom)};
      u_fetp_mac_model.frm.push_back(t);
      e.push_back(i < 2 ? {DEC_HALT, 1'b0} : t.er ? {DEC_INVALID, 1'b1} : {t.d, 1'b0});
    end
    repeat (4) e.push_back(5'h00);
    rxq.delete();
    rec = 1'b1;
    repeat (n + 10) @(posedge txClk);
    rec <= 1'b0;
    rxActive <= 1'b0;
    k = 0;
    while (k < rxq.size() && rxq[k][4:1] !== DEC_HALT) k++;
    foreach (e[i]) chk(32'(rxq[k + i]), 32'(e[i]));
    chk(32'(colSeen), 32'(expCol));
  endtask : frame
  initial
  begin : main
    logic [18:0] sr;
    void'($urandom(32'hec6f_6ece));
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    bus(0, 12'h064, 0);
    chk(rd, 32'({PHYAD_RST, PHYAD_RST, USEED_RST}));
    bus(1, 12'h000, 32'h0000_0080);
    bus(0, 12'h000, 0);
    chk(rd, 32'h0000_0080);
    bus(1, 12'h400, 32'hFFFF_FFFF);
    bus(0, 12'h400, 0);
    chk(rd, 32'h0000_0000);
    bus(1, 12'h060, 32'h0000_0010);
    bus(0, 12'h040, 0);
    chk(32'(rd[12:2]), 32'h0000_07FF);
    bus(0, 12'h060, 0);
    chk(rd, 32'h0000_0000);
    bus(1, 12'h064, 32'h0000_5015);
    bus(0, 12'h064, 0);
    chk(rd, 32'h0000_5295);
    bus(1, 12'h060, 32'h0000_0010);
    bus(0, 12'h040, 0);
    chk(32'(rd[12:2]), 32'h0000_0295);
    togCnt = 0;
    run <= 1'b1;
    repeat (8) @(posedge txClk);
    run <= 1'b0;
    repeat (30) @(posedge core_clk);
    sr = scr_run(11'h295, 8);
    chk(32'(togCnt), 32'(sr[7:0]));
    bus(0, 12'h040, 0);
    chk(32'(rd[12:2]), 32'(sr[18:8]));
    bus(1, 12'h064, 32'h0000_0000);
    bus(1, 12'h060, 32'h0000_0010);
    bus(0, 12'h040, 0);
    chk(32'(rd[12:2]), 32'h0000_07FF);
    // Scrambler bypassed: idle is all ones, so every bit toggles the line
    bus(1, 12'h060, 32'h0000_0002);
    togCnt = 0;
    run <= 1'b1;
    repeat (8) @(posedge txClk);
    run <= 1'b0;
    repeat (30) @(posedge core_clk);
    chk(32'(togCnt), 32'h0000_0028);
    for (int acc = 0; acc < 2; acc++)
    begin
      bus(1, 12'h060, 32'(acc) << 5);
      for (int c = 0; c < 32; c++)
      begin
        bus(1, 12'h044, 32'(c));
        bus(0, 12'h044, 0);
        chk(32'(rd[12:0]), {19'h0_0000, 5'(c), 3'h0, dec_exp(5'(c), acc[0])});
      end
    end
    bus(1, 12'h060, 0);
    run <= 1'b1;
    frame(16'h4000, 1'b1, 1'b1);
    frame(16'h4100, 1'b1, 1'b0);
    frame(16'h4080, 1'b0, 1'b1);
    test_done;
  end
  initial
  begin
    #1_000_000;
    mismatches++;
    test_done;
  end
endmodule : fetp_tx_pcs_tb
